// ===== common/asrn_pkg.sv
// Purpose: Shared constants and types for the accumulator shift unit.
// Assumes: 16-bit accumulator, bit 0 is the sign (most significant bit).
// Notes:   Register offsets are byte addresses on a 32-bit classic Wishbone bus.
package asrn_pkg;
  localparam int unsigned     ADDR_W      = 8;
  localparam logic [7:0]      OFF_ACC     = 8'h00;
  localparam logic [7:0]      OFF_EXT     = 8'h04;
  localparam logic [7:0]      OFF_SAVE    = 8'h08;
  localparam logic [7:0]      OFF_CMD     = 8'h0C;
  localparam logic [7:0]      OFF_FLAGS   = 8'h10;
  localparam logic [7:0]      OFF_INDEX   = 8'h14;
  localparam logic [7:0]      OFF_IRQ_ST  = 8'h18;
  localparam logic [7:0]      OFF_IRQ_MSK = 8'h1C;
  // Command word fields
  localparam int unsigned     CMD_EA_LSB  = 0;
  localparam int unsigned     CMD_EA_W    = 16;
  localparam int unsigned     CMD_OP_LSB  = 16;
  localparam int unsigned     CMD_SAVE    = 19;
  localparam int unsigned     CMD_IDX_LSB = 20;
  // Flags register bit positions
  localparam int unsigned     FLG_Z       = 0;
  localparam int unsigned     FLG_G       = 1;
  localparam int unsigned     FLG_L       = 2;
  localparam int unsigned     FLG_V       = 3;
  // Interrupt status bit positions
  localparam int unsigned     IRQ_DONE    = 0;
  localparam int unsigned     IRQ_OVF     = 1;
  localparam logic [15:0]     RST_WORD    = 16'h0000;
  localparam logic [3:0]      RST_FLAGS   = 4'h0;
  localparam logic [1:0]      RST_IRQ     = 2'h0;
  localparam logic [5:0]      CNT_SINGLE  = 6'h0F;
  localparam logic [5:0]      CNT_EXT     = 6'h1F;
  localparam logic [31:0]     UNMAPPED_RD = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_SINGLE_ARITH_SHIFT = 3'b000,
    OP_EXTENDED_ARITH_SHIFT = 3'b001,
    OP_SINGLE_ROTATE      = 3'b010,
    OP_EXTENDED_ROTATE    = 3'b011,
    OP_SINGLE_NORMALIZE   = 3'b100,
    OP_EXTENDED_NORMALIZE = 3'b101
  } asrn_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_NORM  = 2'b01,
    ST_ACK   = 2'b10
  } asrn_state_t;
endpackage

// ===== hw/asrn_unit.sv
// Purpose: Accumulator shift, rotate and normalize unit with a Wishbone slave.
// Assumes: Bit 0 of a word is its sign and most significant bit; the pair is acc:ext.
// Notes:   Writing the command register starts an operation; ack follows on completion.
// Notes on behaviour
// - Count is the effective address cut to signed 7 bits, -64 to 63.
// - Count is always immediate, also when reached through indirect addressing.
// - Single forms act on acc alone, extended forms on acc:ext pair.
// - Positive count shifts right arithmetically, copying the sign bit.
// - Negative count shifts left, sign kept, bit 1 lost, zeros fill.
// - Arithmetic distance is count modulo 15 single, modulo 31 extended.
// - Extended shifts keep bit 16; bits 1-15 and 17-31 move.
// - Right shift loses low-order bits, left shift loses bits 1 to e.
// - Left shift sets overflow when any lost bit differs from sign.
// - Arithmetic shifts update zero, greater, less, overflow from the result.
// - Save prefix copies acc into the save register before shifting.
// - Single rotate circulates 16 bits, distance modulo 16.
// - Extended rotate circulates 32 bits, distance modulo 32.
// - Rotates leave all flags unchanged.
// - Normalize shifts left until bits 0 and 1 differ, count to index.
// - Normalizing zero writes zero count and shifts nothing.
// - Normalize follows the arithmetic shift rules of its precision.
`timescale 1ns/1ps
module asrn_unit
  import asrn_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [asrn_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     irq_o
);
  import asrn_pkg::*;

  // Machine bits are numbered with 0 as msb: machine bit k is vector bit (W-1-k)
  logic [15:0]  acc_q;
  logic [15:0]  ext_q;
  logic [15:0]  save_q;
  logic [3:0]   flags_q;
  logic [15:0]  index_q;
  logic [2:0]   index_sel_q;
  logic [1:0]   irq_st_q;
  logic [1:0]   irq_msk_q;
  logic [4:0]   norm_cnt_q;
  logic         norm_ext_q;
  asrn_state_t  state_q;

  logic         req;
  logic         wr_cmd;
  logic         wr_reg;
  logic         wr_acc;
  logic         wr_ext;
  logic         wr_flags;
  logic         clr_irq;
  logic         wr_msk;
  logic         is_arith;
  logic         is_norm;
  logic         cmd_q;
  logic         ovf_set;
  logic [31:0]  rd_d;
  logic [6:0]   cnt7;
  asrn_op_t     op;
  logic [31:0]  pair;
  logic [31:0]  res;
  logic         ovf;
  logic         done_pulse;
  logic         norm_done;
  logic [31:0]  norm_val;

  // Arithmetic shift on a W-bit word whose sign is the top bit and never moves
  function automatic logic [32:0] arith_shift(input logic [31:0] v, input logic ext,
                                              input logic right, input logic [4:0] e);
    logic [31:0] o;
    logic        sgn;
    logic        v_f;
    logic [30:0] mag;
    logic [30:0] lost;
    o    = v;
    sgn  = v[31];
    v_f  = 1'b0;
    // Extended form: 30 moving bits are 30..16 (acc) and 14..0 (ext) of the pair (bit 15 kept)
    if (ext) begin
      mag = {v[30:16], v[14:0], 1'b0};
    end else begin
      mag = {v[30:16], 16'h0000};
    end
    if (right) begin
      mag = ext ? ($signed({sgn, mag[30:1]}) >>> e) << 1 : ($signed({sgn, mag[30:1]}) >>> e) << 1;
      if (!ext) begin
        mag[15:0] = 16'h0000;
      end
    end else begin
      lost = mag >> (5'd31 - e);
      if (e != 5'd0) begin
        v_f = sgn ? (lost != ({31{1'b1}} >> (5'd31 - e))) : (lost != 31'h0);
      end
      mag = mag << e;
      if (!ext) begin
        mag[15:0] = 16'h0000;
      end
    end
    if (ext) begin
      o = {sgn, mag[30:16], v[15], mag[15:1]};
    end else begin
      o = {sgn, mag[30:16], v[15:0]};
    end
    return {v_f, o};
  endfunction

  // Shift distance from the count's magnitude, reduced by the form's modulus
  function automatic logic [4:0] dist_of(input logic [6:0] m, input logic [5:0] modulus);
    logic [6:0] r;
    r = m % {1'b0, modulus};
    return r[4:0];
  endfunction

  function automatic logic [3:0] flags_of(input logic [31:0] r, input logic ext, input logic v);
    logic z;
    z = ext ? (r == 32'h0) : (r[31:16] == 16'h0);
    return {v, r[31], !r[31] && !z, z};
  endfunction

  assign req    = wb_cyc_i && wb_stb_i && (state_q == ST_IDLE) && !wb_ack_o;
  assign wr_cmd = req && wb_we_i && (wb_adr_i == OFF_CMD) && wb_sel_i[0] && wb_sel_i[2];
  assign cnt7   = wb_dat_i[6:0];
  assign op     = asrn_op_t'(wb_dat_i[CMD_OP_LSB +: 3]);
  assign pair   = {acc_q, ext_q};

  // Register decode; data writes are only taken while the unit is idle
  assign wr_reg   = req && wb_we_i;
  assign wr_acc   = wr_reg && (wb_adr_i == OFF_ACC) && (wb_sel_i[1:0] == 2'b11);
  assign wr_ext   = wr_reg && (wb_adr_i == OFF_EXT) && (wb_sel_i[1:0] == 2'b11);
  assign wr_flags = wr_reg && (wb_adr_i == OFF_FLAGS) && wb_sel_i[0];
  assign clr_irq  = wr_reg && (wb_adr_i == OFF_IRQ_ST) && wb_sel_i[0];
  assign wr_msk   = wr_reg && (wb_adr_i == OFF_IRQ_MSK) && wb_sel_i[0];
  assign is_arith = (op == OP_SINGLE_ARITH_SHIFT) || (op == OP_EXTENDED_ARITH_SHIFT);
  assign is_norm  = (op == OP_SINGLE_NORMALIZE) || (op == OP_EXTENDED_NORMALIZE);
  assign ovf_set  = wr_cmd && is_arith && ovf;

  logic         right;
  logic [6:0]   mag7;
  logic [4:0]   e_d;
  logic [32:0]  sh;
  always_comb begin
    right = !cnt7[6];
    mag7  = cnt7[6] ? 7'(-cnt7) : cnt7;
    e_d   = 5'd0;
    res   = pair;
    ovf   = 1'b0;
    sh    = 33'h0;
    case (op)
      OP_SINGLE_ARITH_SHIFT: begin
        e_d = dist_of(mag7, CNT_SINGLE);
        sh  = arith_shift(pair, 1'b0, right, e_d);
        res = {sh[31:16], ext_q};
        ovf = sh[32];
      end
      OP_EXTENDED_ARITH_SHIFT: begin
        e_d = dist_of(mag7, CNT_EXT);
        sh  = arith_shift(pair, 1'b1, right, e_d);
        res = sh[31:0];
        ovf = sh[32];
      end
      OP_SINGLE_ROTATE: begin
        e_d = 5'(mag7[3:0]);
        res = right ? {(acc_q >> e_d[3:0]) | (acc_q << (5'd16 - e_d)), ext_q}
                    : {(acc_q << e_d[3:0]) | (acc_q >> (5'd16 - e_d)), ext_q};
      end
      OP_EXTENDED_ROTATE: begin
        e_d = mag7[4:0];
        res = right ? ((pair >> e_d) | (pair << (6'd32 - e_d)))
                    : ((pair << e_d) | (pair >> (6'd32 - e_d)));
      end
      default: begin
        res = pair;
      end
    endcase
  end

  // Normalize one place per cycle using the same left-shift rule as the shifts
  logic [32:0] norm_step;
  assign norm_step = arith_shift(pair, norm_ext_q, 1'b0, 5'd1);
  assign norm_val  = norm_ext_q ? pair : {acc_q, 16'h0000};
  assign norm_done = (norm_val == 32'h0) || (acc_q[15] != acc_q[14]);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_cmd && is_norm) begin
            state_q <= ST_NORM;
          end else if (req) begin
            state_q <= ST_ACK;
          end
        end
        ST_NORM: begin
          if (norm_done) begin
            state_q <= ST_ACK;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Count restarts with every normalize, so a stale count never leaks into the index
  always_ff @(posedge core_clk) begin
    if (srst) begin
      norm_cnt_q <= 5'd0;
      norm_ext_q <= 1'b0;
    end else if (state_q == ST_IDLE && wr_cmd && is_norm) begin
      norm_cnt_q <= 5'd0;
      norm_ext_q <= (op == OP_EXTENDED_NORMALIZE);
    end else if (state_q == ST_NORM && !norm_done) begin
      norm_cnt_q <= norm_cnt_q + 5'd1;
    end
  end

  // Bus writes to data registers are refused while a normalize runs (no ack yet)
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_q <= RST_WORD;
      ext_q <= RST_WORD;
    end else if (state_q == ST_NORM) begin
      if (!norm_done) begin
        acc_q <= norm_step[31:16];
        if (norm_ext_q) begin
          ext_q <= norm_step[15:0];
        end
      end
    end else if (wr_cmd) begin
      acc_q <= res[31:16];
      ext_q <= res[15:0];
    end else if (wr_acc) begin
      acc_q <= wb_dat_i[15:0];
    end else if (wr_ext) begin
      ext_q <= wb_dat_i[15:0];
    end
  end

  // Copy takes the word before the shift lands in the same edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      save_q <= RST_WORD;
    end else if (wr_cmd && wb_dat_i[CMD_SAVE]) begin
      save_q <= acc_q;
    end
  end

  // Rotates and normalize leave flags alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_q <= RST_FLAGS;
    end else if (wr_cmd && is_arith) begin
      flags_q <= flags_of(res, op == OP_EXTENDED_ARITH_SHIFT, ovf);
    end else if (wr_flags) begin
      flags_q <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      index_sel_q <= 3'd0;
    end else if (wr_cmd) begin
      index_sel_q <= wb_dat_i[CMD_IDX_LSB +: 3];
    end
  end

  // Written once when shifting stops; the count never shows a partial value
  always_ff @(posedge core_clk) begin
    if (srst) begin
      index_q <= RST_WORD;
    end else if (state_q == ST_NORM && norm_done) begin
      index_q <= (norm_val == 32'h0) ? 16'h0000 : {11'h000, norm_cnt_q};
    end
  end

  // Done marks the end of a command; plain register traffic does not raise it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_q <= 1'b0;
    end else if (wr_cmd) begin
      cmd_q <= 1'b1;
    end else if (state_q == ST_ACK) begin
      cmd_q <= 1'b0;
    end
  end

  assign done_pulse = (state_q == ST_ACK) && cmd_q;

  // Set beats a same-cycle write-one clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_st_q <= RST_IRQ;
    end else begin
      irq_st_q[IRQ_DONE] <= done_pulse || (irq_st_q[IRQ_DONE] && !(clr_irq && wb_dat_i[IRQ_DONE]));
      irq_st_q[IRQ_OVF]  <= ovf_set || (irq_st_q[IRQ_OVF] && !(clr_irq && wb_dat_i[IRQ_OVF]));
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_msk_q <= RST_IRQ;
    end else if (wr_msk) begin
      irq_msk_q <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st_q & irq_msk_q);
    end
  end

  // Read data is formed in the answer state only, so the bus sees zero outside ack
  always_comb begin
    rd_d = UNMAPPED_RD;
    if (state_q != ST_ACK) begin
      rd_d = UNMAPPED_RD;
    end else if (wb_adr_i == OFF_ACC) begin
      rd_d = {16'h0000, acc_q};
    end else if (wb_adr_i == OFF_EXT) begin
      rd_d = {16'h0000, ext_q};
    end else if (wb_adr_i == OFF_SAVE) begin
      rd_d = {16'h0000, save_q};
    end else if (wb_adr_i == OFF_FLAGS) begin
      rd_d = {28'h000_0000, flags_q};
    end else if (wb_adr_i == OFF_INDEX) begin
      rd_d = {13'h0000, index_sel_q, index_q};
    end else if (wb_adr_i == OFF_IRQ_ST) begin
      rd_d = {30'h0000_0000, irq_st_q};
    end else if (wb_adr_i == OFF_IRQ_MSK) begin
      rd_d = {30'h0000_0000, irq_msk_q};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= UNMAPPED_RD;
    end else begin
      wb_ack_o <= (state_q == ST_ACK) && wb_cyc_i && wb_stb_i;
      wb_dat_o <= rd_d;
    end
  end
endmodule

// ===== verif/asrn_host_model.sv
// Purpose: Decode-side stand-in that issues unit commands over the bus.
// Assumes: Classic Wishbone, one transfer at a time, all lanes enabled.
// Notes:   The wait is unbounded here; the bench timeout cuts a hang.
`timescale 1ns/1ps
module asrn_host_model (
  input  wire logic        core_clk,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat
);
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Stale write data would hide a slave that samples outside the cycle
    dat <= ~d;
    @(posedge core_clk);
  endtask
endmodule

// ===== verif/asrn_unit_chk_sva.sv
// Purpose: Port-level bus and interrupt checks for the shift unit.
// Assumes: One classic Wishbone master, one request at a time.
// Notes:   Datapath results are judged by the bench, not here.
`timescale 1ns/1ps
module asrn_unit_chk
  import asrn_pkg::*;
(
  input wire logic                         core_clk,
  input wire logic                         srst,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [asrn_pkg::ADDR_W-1:0]  wb_adr_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [31:0]                  wb_dat_i,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic                         irq_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_recent_ack;
    wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endsequence
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
  AST_ACK_NEEDS_REQ:
    assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack without request");
  AST_DAT_QUIET:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
  AST_PLAIN_ACK:
    assert property (s_req ##0 (wb_adr_i != OFF_CMD) |-> ##[1:2] wb_ack_o) else $error("plain access slow");
  AST_OP_BOUND:
    assert property (s_req |-> ##[1:36] wb_ack_o) else $error("operation never answered");
  AST_RESET_QUIET:
    assert property ($fell(srst) |-> !wb_ack_o && !irq_o) else $error("outputs busy after reset");
  AST_IRQ_RISE:
    assert property ($rose(irq_o) |-> s_recent_ack) else $error("irq rose without access");
  AST_IRQ_FALL:
    assert property ($fell(irq_o) |-> s_recent_ack) else $error("irq fell without access");
endmodule

// ===== verif/asrn_unit_tb.sv
// Purpose: Self-checking bench for the shift, rotate and normalize unit.
// Assumes: Hardware bit 15 of a word is the machine sign bit.
// Notes:   Flags read back as {V,L,G,Z}.
`timescale 1ns/1ps
module asrn_unit_tb;
  import asrn_pkg::*;
  logic        core_clk, srst, cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  asrn_unit i_dut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
  asrn_host_model u_host (.core_clk(core_clk), .wb_ack_o(ack), .wb_dat_o(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat(wdat));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
    cmp(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask
  function automatic logic [31:0] cw(asrn_op_t o, logic [6:0] n, logic s, logic [2:0] x);
    return {9'h0, x, s, o, 9'h0, n};
  endfunction
  task automatic run(input logic [15:0] a, e, input logic [31:0] c, input logic [15:0] ea, ee);
    wr(OFF_ACC, {16'h0000, a});
    wr(OFF_EXT, {16'h0000, e});
    wr(OFF_CMD, c);
    chk(OFF_ACC, {16'h0000, ea});
    chk(OFF_EXT, {16'h0000, ee});
  endtask
  initial begin
    srst = 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk(OFF_ACC, 32'h0000_0000);
    chk(OFF_IRQ_ST, 32'h0000_0000);
    chk(8'h20, 32'h0000_0000);
    $display("test reset done");
    // High effective address bits above the 7-bit count must be dropped
    run(16'h8010, 16'h0000, cw(OP_SINGLE_ARITH_SHIFT, 7'h04, 1'b0, 3'h0) | 32'h0000_FF80, 16'hF801, 16'h0000);
    chk(OFF_FLAGS, 32'h0000_0004);
    run(16'h2001, 16'h0000, cw(OP_SINGLE_ARITH_SHIFT, 7'h7D, 1'b0, 3'h0), 16'h0008, 16'h0000);
    chk(OFF_FLAGS, 32'h0000_000A);
    run(16'h0001, 16'h0000, cw(OP_SINGLE_ARITH_SHIFT, 7'h40, 1'b0, 3'h0), 16'h0010, 16'h0000);
    chk(OFF_FLAGS, 32'h0000_0002);
    run(16'h0000, 16'h0000, cw(OP_SINGLE_ARITH_SHIFT, 7'h0F, 1'b0, 3'h0), 16'h0000, 16'h0000);
    chk(OFF_FLAGS, 32'h0000_0001);
    run(16'h1234, 16'h0000, cw(OP_SINGLE_ARITH_SHIFT, 7'h01, 1'b1, 3'h0), 16'h091A, 16'h0000);
    chk(OFF_SAVE, 32'h0000_1234);
    $display("test single shift done");
    run(16'h0000, 16'h0001, cw(OP_EXTENDED_ARITH_SHIFT, 7'h71, 1'b0, 3'h0), 16'h0001, 16'h0000);
    run(16'h8000, 16'h8000, cw(OP_EXTENDED_ARITH_SHIFT, 7'h10, 1'b0, 3'h0), 16'hFFFF, 16'hC000);
    chk(OFF_FLAGS, 32'h0000_0004);
    run(16'h4000, 16'h0000, cw(OP_EXTENDED_ARITH_SHIFT, 7'h7F, 1'b0, 3'h0), 16'h0000, 16'h0000);
    chk(OFF_FLAGS, 32'h0000_0009);
    $display("test extended shift done");
    run(16'h1234, 16'h5A5A, cw(OP_SINGLE_ROTATE, 7'h04, 1'b0, 3'h0), 16'h4123, 16'h5A5A);
    run(16'h1234, 16'h5A5A, cw(OP_SINGLE_ROTATE, 7'h7C, 1'b0, 3'h0), 16'h2341, 16'h5A5A);
    run(16'h1234, 16'h5A5A, cw(OP_SINGLE_ROTATE, 7'h3F, 1'b0, 3'h0), 16'h2468, 16'h5A5A);
    run(16'h1234, 16'hABCD, cw(OP_EXTENDED_ROTATE, 7'h10, 1'b0, 3'h0), 16'hABCD, 16'h1234);
    run(16'h8000, 16'h0001, cw(OP_EXTENDED_ROTATE, 7'h7F, 1'b0, 3'h0), 16'h0000, 16'h0003);
    chk(OFF_FLAGS, 32'h0000_0009);
    $display("test rotate done");
    run(16'h0010, 16'h0000, cw(OP_SINGLE_NORMALIZE, 7'h00, 1'b0, 3'h3), 16'h4000, 16'h0000);
    chk(OFF_INDEX, 32'h0003_000A);
    run(16'hF800, 16'h0000, cw(OP_SINGLE_NORMALIZE, 7'h00, 1'b0, 3'h1), 16'h8000, 16'h0000);
    chk(OFF_INDEX, 32'h0001_0004);
    run(16'h0000, 16'h0000, cw(OP_SINGLE_NORMALIZE, 7'h00, 1'b0, 3'h5), 16'h0000, 16'h0000);
    chk(OFF_INDEX, 32'h0005_0000);
    run(16'h0000, 16'h8001, cw(OP_EXTENDED_NORMALIZE, 7'h00, 1'b0, 3'h2), 16'h4000, 16'h8000);
    chk(OFF_INDEX, 32'h0002_001D);
    $display("test normalize done");
    cmp({31'h0, irq}, 32'h0000_0000);
    chk(OFF_IRQ_ST, 32'h0000_0003);
    wr(OFF_IRQ_MSK, 32'h0000_0002);
    cmp({31'h0, irq}, 32'h0000_0001);
    wr(OFF_IRQ_ST, 32'h0000_0002);
    chk(OFF_IRQ_ST, 32'h0000_0001);
    cmp({31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    end_sim();
  end
endmodule
bind asrn_unit asrn_unit_chk u_chk (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
